// ---- src/qwe_pkg.sv ----
// Shared constants and types of the Q&A watchdog cycle evaluator
package qwe_pkg;
	// ==========================================================
	// Register map (Avalon word addresses)
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_MASK = 3'h2;
	localparam logic [2:0] ADDR_STATE = 3'h3;
	// ==========================================================
	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int EV_ANSWER_FAULT = 0;
	localparam int EV_WATCHDOG_FAULT = 1;
	localparam int EV_CYCLE_PASS = 2;
	localparam int NUM_EVENTS = 3;
	localparam int STATE_TALLY_LSB = 0;
	localparam int STATE_FAIL_LSB = 4;
	localparam int STATE_AFLAG_BIT = 8;
	localparam int STATE_WFLAG_BIT = 9;
	// ==========================================================
	// Reset values and counts
	localparam logic CTRL_ENABLE_RST = 1'b1;
	localparam logic [NUM_EVENTS-1:0] MASK_RST = 3'h0;
	localparam logic [2:0] TALLY_FULL = 3'h4;
	localparam logic [1:0] W1_EXPECTED = 2'h3;
	localparam logic [3:0] FAIL_MAX = 4'hF;
	localparam logic [3:0] FAIL_RST = 4'h0;
	// ==========================================================
	// Answer event bundle from the SPI answer checker
	typedef struct packed {
		logic valid;
		logic correct;
		logic in_window2;
		logic window2_end;
	} qwe_answer_t;
	// Per-cycle verdict bundle
	typedef struct packed {
		logic cycle_start;
		logic new_question;
		logic fail_inc;
		logic fail_dec;
	} qwe_verdict_t;
endpackage : qwe_pkg

// ---- src/qwe_sticky.sv ----
// One sticky status bit, set by hardware, cleared by writing one
module qwe_sticky (
	input wire logic clk,
	input wire logic rst,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	// Set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule : qwe_sticky

// ---- src/qwe_evaluator.sv ----
// Q&A watchdog multi-answer cycle evaluator with Avalon-MM registers
module qwe_evaluator
	import qwe_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire qwe_answer_t ANSWER,
	output qwe_verdict_t VERDICT,
	output logic ANSWER_FAULT,
	output logic WATCHDOG_FAULT,
	output logic [3:0] FAIL_COUNT,
	output logic IRQ,
	input wire logic [2:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);
	// ==========================================================
	// Cycle bookkeeping
	logic enable;
	logic [2:0] tally;
	logic [1:0] w1_count;
	logic w2_seen;
	logic wrong_seen;
	logic [2:0] next_tally;
	logic next_wrong;
	logic fourth;
	logic at_end;
	logic good_cycle;
	logic cycle_done;

	always_comb begin
		next_tally = tally;
		next_wrong = wrong_seen;
		if (ANSWER.valid) begin
			next_tally = tally + 3'h1;
			next_wrong = wrong_seen | ~ANSWER.correct;
		end
	end

	assign fourth = enable && ANSWER.valid && next_tally == TALLY_FULL;
	assign at_end = enable && ANSWER.window2_end && !fourth;
	// Correct only as three in window one, the last in window two, all right
	assign good_cycle = fourth && !next_wrong && w1_count == W1_EXPECTED
		&& !w2_seen && ANSWER.in_window2;
	assign cycle_done = fourth || at_end;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !enable || cycle_done) begin
			tally <= 3'h0;
			w1_count <= 2'h0;
			w2_seen <= 1'b0;
			wrong_seen <= 1'b0;
		end else if (ANSWER.valid) begin
			tally <= next_tally;
			wrong_seen <= next_wrong;
			if (ANSWER.in_window2) begin
				w2_seen <= 1'b1;
			end else if (w1_count != W1_EXPECTED) begin
				w1_count <= w1_count + 2'h1;
			end else begin
				w2_seen <= 1'b1; // A fourth in window one spoils the split
			end
		end
	end

	// ==========================================================
	// Verdict, flags and failure counter
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			VERDICT <= '0;
		end else begin
			VERDICT.cycle_start <= cycle_done;
			VERDICT.new_question <= good_cycle;
			VERDICT.fail_inc <= cycle_done && !good_cycle;
			VERDICT.fail_dec <= good_cycle;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ANSWER_FAULT <= 1'b0;
			WATCHDOG_FAULT <= 1'b0;
		end else if (cycle_done) begin
			ANSWER_FAULT <= next_wrong && !good_cycle;
			WATCHDOG_FAULT <= !good_cycle;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			FAIL_COUNT <= FAIL_RST;
		end else if (cycle_done && !good_cycle && FAIL_COUNT != FAIL_MAX) begin
			FAIL_COUNT <= FAIL_COUNT + 4'h1;
		end else if (good_cycle && FAIL_COUNT != FAIL_RST) begin
			FAIL_COUNT <= FAIL_COUNT - 4'h1;
		end
	end

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then a one-cycle acknowledge
	logic [NUM_EVENTS-1:0] status;
	logic [NUM_EVENTS-1:0] mask;
	logic [NUM_EVENTS-1:0] ev_set;
	logic take_write;
	logic status_clr;
	logic [31:0] next_readdata;

	assign take_write = AVS_WRITE && !AVS_WAITREQUEST;
	assign status_clr = take_write && AVS_ADDRESS == ADDR_STATUS;
	assign ev_set = {good_cycle, cycle_done && !good_cycle,
		cycle_done && next_wrong && !good_cycle};

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			enable <= CTRL_ENABLE_RST;
			mask <= MASK_RST;
		end else if (take_write && AVS_ADDRESS == ADDR_CTRL) begin
			enable <= AVS_WRITEDATA[CTRL_ENABLE_BIT];
		end else if (take_write && AVS_ADDRESS == ADDR_MASK) begin
			mask <= AVS_WRITEDATA[NUM_EVENTS-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_status
			qwe_sticky u_bit (
				.clk(CLOCK),
				.rst(SYS_RST),
				.set(ev_set[gi]),
				.clr(status_clr && AVS_WRITEDATA[gi]),
				.q(status[gi])
			);
		end
	endgenerate

	always_comb begin
		next_readdata = 32'h0;
		unique case (AVS_ADDRESS)
			ADDR_CTRL: next_readdata[CTRL_ENABLE_BIT] = enable;
			ADDR_STATUS: next_readdata[NUM_EVENTS-1:0] = status;
			ADDR_MASK: next_readdata[NUM_EVENTS-1:0] = mask;
			ADDR_STATE: begin
				next_readdata[STATE_TALLY_LSB +: 3] = tally;
				next_readdata[STATE_FAIL_LSB +: 4] = FAIL_COUNT;
				next_readdata[STATE_AFLAG_BIT] = ANSWER_FAULT;
				next_readdata[STATE_WFLAG_BIT] = WATCHDOG_FAULT;
			end
			default: next_readdata = 32'h0;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			AVS_READDATA <= 32'h0;
		end else if (AVS_READ && AVS_WAITREQUEST) begin
			AVS_READDATA <= next_readdata;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status & mask);
		end
	end

	// ==========================================================
	// Checks
	a_good_cycle_dec: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		good_cycle |=> VERDICT.new_question && VERDICT.fail_dec && !WATCHDOG_FAULT
			&& !ANSWER_FAULT)
		else $error("correct sequence not rewarded");
	a_short_end_fail: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		at_end |=> VERDICT.cycle_start && VERDICT.fail_inc && !VERDICT.new_question
			&& WATCHDOG_FAULT)
		else $error("short cycle not failed at window end");
	a_fourth_ends: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		fourth && !good_cycle |=> VERDICT.cycle_start && VERDICT.fail_inc
			&& WATCHDOG_FAULT && tally == 3'h0)
		else $error("bad fourth answer not failed");
	a_answer_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		cycle_done && !good_cycle |=> ANSWER_FAULT == $past(next_wrong))
		else $error("answer fault flag wrong");
	a_tally_count: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		enable && ANSWER.valid && !cycle_done |=> tally == $past(tally) + 3'h1)
		else $error("tally did not count");
	a_w1_four_fail: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		fourth && !ANSWER.in_window2 && !w2_seen |=> !VERDICT.new_question
			&& WATCHDOG_FAULT)
		else $error("four in window one accepted");
	a_irq_level: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		|(status & mask) |=> IRQ)
		else $error("interrupt missing");
	a_bus_ack: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus acknowledge timing");
	c_good: cover property (@(posedge CLOCK) disable iff (SYS_RST) good_cycle);
	c_short: cover property (@(posedge CLOCK) disable iff (SYS_RST) at_end && tally != 3'h0);
	c_bad4: cover property (@(posedge CLOCK) disable iff (SYS_RST) fourth && !good_cycle);
	c_irq: cover property (@(posedge CLOCK) disable iff (SYS_RST) IRQ);
endmodule : qwe_evaluator

// ---- verification/qwe_host.sv ----
// Host model that sends watchdog answers and window-two closes
module qwe_host
	import qwe_pkg::*;
(
	input wire logic CLOCK,
	output qwe_answer_t ANSWER
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ANSWER = '0;
	// ==========================================================
	// Answer delivery
	task automatic send(input logic w2, input logic ok);
		@(posedge CLOCK);
		ANSWER <= '{valid: 1'b1, correct: ok, in_window2: w2, window2_end: 1'b0};
		@(posedge CLOCK);
		ANSWER <= '{valid: 1'b0, correct: ~ok, in_window2: ~w2, window2_end: 1'b0};
	endtask : send
	task automatic close_w2();
		@(posedge CLOCK);
		ANSWER <= '{valid: 1'b0, correct: 1'b0, in_window2: 1'b1, window2_end: 1'b1};
		@(posedge CLOCK);
		ANSWER <= '0;
	endtask : close_w2
endmodule : qwe_host

// ---- verification/tb_top.sv ----
// Self-checking bench of the watchdog cycle evaluator
module tb_top
	import qwe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	qwe_answer_t answer;
	qwe_verdict_t verdict;
	logic answer_fault, watchdog_fault, irq, avs_waitrequest;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] fail_count;
	logic [3:0] fc = 4'h0;
	logic [2:0] avs_address = 3'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	int n1s[10] = '{3, 3, 0, 2, 2, 4, 4, 0, 3, 3};
	int n2s[10] = '{1, 0, 0, 1, 2, 0, 0, 4, 1, 1};
	logic [3:0] bads[10] = '{4'h8, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h4, 4'hF, 4'h0, 4'h0};
	qwe_evaluator u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .ANSWER(answer), .VERDICT(verdict),
		.ANSWER_FAULT(answer_fault), .WATCHDOG_FAULT(watchdog_fault), .FAIL_COUNT(fail_count),
		.IRQ(irq), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest));
	qwe_host u_host (.CLOCK(clock), .ANSWER(answer));
	initial begin
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	// ==========================================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// One watchdog cycle; bad marks the answers given wrong
	task automatic wd(input int n1, input int n2, input logic [3:0] bad);
		logic good;
		good = n1 == 3 && n2 == 1 && bad == 4'h0;
		for (int i = 0; i < n1 + n2; i++) u_host.send(i >= n1, ~bad[i]);
		if (n1 + n2 < 4) u_host.close_w2();
		#1;
		chk(32'(verdict), good ? 32'hD : 32'hA);
		// Failure counter saturates at both ends
		if (good && fc != 4'h0) begin
			fc = fc - 4'h1;
		end else if (!good && fc != 4'hF) begin
			fc = fc + 4'h1;
		end
		chk(32'({answer_fault, watchdog_fault, fail_count}), 32'({|bad, ~good, fc}));
	endtask : wd
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		for (int k = 0; k < 10; k++) wd(n1s[k], n2s[k], bads[k]);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h7);
		chk(32'(irq), 32'h0);
		bus(1'b1, ADDR_MASK, 32'h4);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h1);
		bus(1'b1, ADDR_STATUS, 32'h7);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 3'h5, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) u_host.send(1'b0, 1'b1);
		bus(1'b0, ADDR_STATE, 32'h0);
		chk(rd, 32'h60);
		bus(1'b1, ADDR_CTRL, 32'h1);
		wd(3, 1, 4'h0);
		// Mid-run reset, then both ends of the failure counter
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		fc = 4'h0;
		bus(1'b0, ADDR_STATE, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, ADDR_MASK, 32'h0);
		chk(rd, 32'h0);
		chk(32'({verdict, irq}), 32'h0);
		wd(3, 1, 4'h0);
		for (int k = 0; k < 16; k++) wd(0, 0, 4'h0);
		end_sim();
	end
endmodule : tb_top
